// ---- two_level_vectored_irq_unit.sv ----
// vectored two-level interrupt unit: masks, priorities, arbitration
// assumes the core pulses instr_done, return_from_irq_op_done and irq_ack on one clock
`timescale 1ns/1ps
module two_level_vectored_irq_unit
    import irq_unit_pkg::*;
(
    input  wire logic                ref_clk_in,     // system clock
    input  wire logic                rst_in,         // sync reset, high
    input  wire logic                clk_en_in,      // freezes all state
    input  wire sfr_bus_t            sfr_bus_in,     // byte register access
    input  wire bit_bus_t            bit_bus_in,     // bit register access
    input  wire logic [NUM_SRC-1:0]  pend_in,        // pending flags by order
    input  wire logic                t2_high_flag_in, // timer2 high overflow
    input  wire logic                instr_done_in,  // non-return instr ends
    input  wire logic                return_from_irq_op_done_in,   // return instr ends
    input  wire logic                irq_ack_in,     // core starts long call
    output logic [7:0]               sfr_rdata_out,  // read data
    output logic                     irq_req_out,    // request to core
    output logic [15:0]              vector_out,     // call target
    output logic [NUM_SRC-1:0]       hw_clear_out,   // flag clear pulses
    output logic                     hi_active_out,  // high level in service
    output logic                     lo_active_out   // low level in service
);
    // register state
    logic [7:0] en0_reg;                  // primary enable
    logic [6:0] pri0_reg;                 // primary priority bits 6..0
    logic [7:0] en1_reg;                  // extended enable 1
    logic [7:0] pri1_reg;                 // extended priority 1
    logic [7:0] en2_reg;                  // extended enable 2
    logic [7:0] pri2_reg;                 // extended priority 2
    logic       block_reg;                // one instruction after return
    logic       hi_act_reg;               // high routine running
    logic       lo_act_reg;               // low routine running
    logic [IDX_W-1:0] win_idx_reg;        // source behind vector_out
    logic       win_hi_reg;               // its level

    // lowest-numbered set bit, and whether any is set
    function automatic logic [IDX_W:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [IDX_W:0] r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, i[IDX_W-1:0]};
            end
        end
        return r;
    endfunction : first_set

    // vector for a source: base plus eight bytes per step
    function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] idx);
        return VEC_BASE + {8'h00, idx, 3'b000};
    endfunction : vec_of

    // bit write merged into a byte
    function automatic logic [7:0] bit_put(input logic [7:0] cur,
                                           input logic [2:0] pos,
                                           input logic       val);
        logic [7:0] r;
        r = cur;
        r[pos] = val;
        return r;
    endfunction : bit_put

    // register decode
    wire byte_en0  = sfr_bus_in.wr && (sfr_bus_in.addr == ADDR_EN0);
    wire byte_pri0 = sfr_bus_in.wr && (sfr_bus_in.addr == ADDR_PRI0);
    wire byte_en1  = sfr_bus_in.wr && (sfr_bus_in.addr == ADDR_EN1);
    wire byte_pri1 = sfr_bus_in.wr && (sfr_bus_in.addr == ADDR_PRI1);
    wire byte_en2  = sfr_bus_in.wr && (sfr_bus_in.addr == ADDR_EN2);
    wire byte_pri2 = sfr_bus_in.wr && (sfr_bus_in.addr == ADDR_PRI2);
    wire [7:0] bit_byte = bit_bus_in.addr & BIT_BASE_MASK;
    wire [2:0] bit_pos  = bit_bus_in.addr[2:0];
    wire bit_en0  = bit_bus_in.wr && (bit_byte == ADDR_EN0);
    wire bit_pri0 = bit_bus_in.wr && (bit_byte == ADDR_PRI0);
    wire [7:0] pri0_full = PRI0_FIXED | {1'b0, pri0_reg};

    // next register values, byte write before bit write
    wire [7:0] en0_next  = byte_en0 ? sfr_bus_in.wdata :
                           bit_en0 ? bit_put(en0_reg, bit_pos, bit_bus_in.val) :
                           en0_reg;
    wire [7:0] pri0_wr   = byte_pri0 ? sfr_bus_in.wdata :
                           bit_pri0 ? bit_put(pri0_full, bit_pos, bit_bus_in.val) :
                           pri0_full;
    wire [6:0] pri0_next = pri0_wr[6:0];
    wire [7:0] en1_next  = byte_en1 ? sfr_bus_in.wdata : en1_reg;
    wire [7:0] pri1_next = byte_pri1 ? sfr_bus_in.wdata : pri1_reg;
    wire [7:0] en2_next  = byte_en2 ? (sfr_bus_in.wdata & EN2_MASK) : en2_reg;
    wire [7:0] pri2_next = byte_pri2 ? (sfr_bus_in.wdata & EN2_MASK) : pri2_reg;

    // read mux, unmapped reads zero
    wire [7:0] rdata_next =
        !sfr_bus_in.rd                  ? sfr_rdata_out :
        (sfr_bus_in.addr == ADDR_EN0)   ? en0_reg :
        (sfr_bus_in.addr == ADDR_PRI0)  ? pri0_full :
        (sfr_bus_in.addr == ADDR_EN1)   ? en1_reg :
        (sfr_bus_in.addr == ADDR_PRI1)  ? pri1_reg :
        (sfr_bus_in.addr == ADDR_EN2)   ? en2_reg :
        (sfr_bus_in.addr == ADDR_PRI2)  ? pri2_reg : 8'h00;

    // per-source masks and levels in fixed order
    wire [NUM_SRC-1:0] src_en  = {en2_reg[3:0], en1_reg, en0_reg[6:0]};
    wire [NUM_SRC-1:0] src_pri = {pri2_reg[3:0], pri1_reg, pri0_reg};
    // flags are level inputs, never stored here; read-only and indirect
    // flags arrive the same way and a cleared mask is what stops them
    wire [NUM_SRC-1:0] flags   = pend_in |
                                 ({{(NUM_SRC-1){1'b0}}, t2_high_flag_in}
                                  << T2_SRC);
    // masked flags stay pending outside, ready once enabled again
    wire [NUM_SRC-1:0] elig    = flags & src_en &
                                 {NUM_SRC{en0_reg[GLOBAL_BIT]}};
    // high may enter unless high runs; low only when nothing runs
    wire [NUM_SRC-1:0] hi_cand = elig & src_pri &
                                 {NUM_SRC{!hi_act_reg}};
    wire [NUM_SRC-1:0] lo_cand = elig & ~src_pri &
                                 {NUM_SRC{!hi_act_reg && !lo_act_reg}};
    wire [IDX_W:0] hi_pick = first_set(hi_cand);
    wire [IDX_W:0] lo_pick = first_set(lo_cand);
    // no new request on the return, on the instruction after it, or on ack
    wire hold = block_reg || return_from_irq_op_done_in || irq_ack_in;
    wire [IDX_W-1:0] pick_idx = hi_pick[IDX_W] ? hi_pick[IDX_W-1:0] :
                                                 lo_pick[IDX_W-1:0];
    wire req_next = !hold && (hi_pick[IDX_W] || lo_pick[IDX_W]);
    // hardware clear only for the first four sources
    wire ack_ok  = irq_ack_in && irq_req_out;
    wire clr_hit = ack_ok && (win_idx_reg < IDX_W'(HWCLR_CNT));
    wire [NUM_SRC-1:0] clr_next = clr_hit ?
        NUM_SRC'(1) << win_idx_reg : '0;

    // register file
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            en0_reg  <= RST_EN;
            pri0_reg <= RST_PRI[6:0];
            en1_reg  <= RST_EN;
            pri1_reg <= RST_PRI;
            en2_reg  <= RST_EN;
            pri2_reg <= RST_PRI;
            sfr_rdata_out <= 8'h00;
        end else if (clk_en_in) begin
            en0_reg  <= en0_next;
            pri0_reg <= pri0_next;
            en1_reg  <= en1_next;
            pri1_reg <= pri1_next;
            en2_reg  <= en2_next;
            pri2_reg <= pri2_next;
            sfr_rdata_out <= rdata_next;
        end
    end

    // request, vector and clear outputs, one detect clock
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_req_out  <= 1'b0;
            vector_out   <= VEC_RESET;
            win_idx_reg  <= '0;
            win_hi_reg   <= 1'b0;
            hw_clear_out <= '0;
        end else if (clk_en_in) begin
            irq_req_out  <= req_next;
            vector_out   <= req_next ? vec_of(pick_idx) : vector_out;
            win_idx_reg  <= req_next ? pick_idx : win_idx_reg;
            win_hi_reg   <= req_next ? hi_pick[IDX_W] : win_hi_reg;
            hw_clear_out <= clr_next;
        end
    end

    // in-service levels and post-return hold
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            hi_act_reg <= 1'b0;
            lo_act_reg <= 1'b0;
            block_reg  <= 1'b0;
        end else if (clk_en_in) begin
            // set on return wins over clear by an instruction end
            if (return_from_irq_op_done_in) begin
                block_reg <= 1'b1;
            end else if (instr_done_in) begin
                block_reg <= 1'b0;
            end
            if (ack_ok && win_hi_reg) begin
                hi_act_reg <= 1'b1;
            end else if (ack_ok) begin
                lo_act_reg <= 1'b1;
            end else if (return_from_irq_op_done_in && hi_act_reg) begin
                hi_act_reg <= 1'b0;
            end else if (return_from_irq_op_done_in) begin
                lo_act_reg <= 1'b0;
            end
        end
    end

    // level status straight from flops
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            hi_active_out <= 1'b0;
            lo_active_out <= 1'b0;
        end else if (clk_en_in) begin
            hi_active_out <= hi_act_reg;
            lo_active_out <= lo_act_reg;
        end
    end

    // checks, all on the system clock and quiet during reset

    // no request one clock after the global bit is seen low
    chk_global_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && !en0_reg[GLOBAL_BIT]) |=> !irq_req_out)
        else $error("request while global enable low");

    // the return itself never raises a request
    chk_return_from_irq_op_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && return_from_irq_op_done_in) |=> !irq_req_out)
        else $error("request right after return");

    // call target follows the winning source
    chk_vector_map: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        irq_req_out |-> (vector_out == VEC_BASE + {8'h00, win_idx_reg, 3'b000}))
        else $error("vector does not match source");

    // a taken call on sources zero to three pulses their clear
    chk_hw_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && ack_ok && win_idx_reg < IDX_W'(HWCLR_CNT))
        |=> hw_clear_out[$past(win_idx_reg)])
        else $error("missing hardware clear");

    // software-cleared sources never see a pulse
    chk_clear_scope: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        hw_clear_out[NUM_SRC-1:HWCLR_CNT] == '0)
        else $error("clear on software-cleared source");

    // a running high routine blocks every request
    chk_high_nopreempt: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && hi_act_reg) |=> !irq_req_out)
        else $error("high routine preempted");

    // during a low routine only high sources may ask
    chk_low_wait: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (irq_req_out && lo_act_reg) |-> win_hi_reg)
        else $error("low request during low routine");

    // priority bit seven always reads one
    chk_pri_bit7: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && sfr_bus_in.rd && sfr_bus_in.addr == ADDR_PRI0)
        |=> sfr_rdata_out[7])
        else $error("priority bit 7 not one");

    // source zero wins in one clock unless a high source waits
    chk_detect_one: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && !hold && !hi_act_reg && !lo_act_reg && elig[0] &&
         (src_pri[0] || !(|(elig & src_pri)))) |=>
        (irq_req_out && win_idx_reg == '0))
        else $error("source zero not granted in one clock");

    // any eligible source with nothing running asks after one clock
    chk_detect_any: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && !hold && !hi_act_reg && !lo_act_reg && (|elig)) |=> irq_req_out)
        else $error("eligible source not requested");

    // a waiting high source goes first, also over a low routine
    chk_high_first: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && !hold && !hi_act_reg && (|(elig & src_pri))) |=>
        (irq_req_out && win_hi_reg))
        else $error("high source not granted");

    // the call start drops the request
    chk_ack_drop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && irq_ack_in) |=> !irq_req_out)
        else $error("request held over call start");

    // hold stays until the instruction after the return ends
    chk_block_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && block_reg && !instr_done_in) |=> (block_reg && !irq_req_out))
        else $error("hold lost before next instruction");

    // the instruction after the return ends the hold
    chk_block_release: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && block_reg && instr_done_in && !return_from_irq_op_done_in) |=> !block_reg)
        else $error("hold not released");

    // clear pulses last exactly one clock
    chk_clear_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && (|hw_clear_out)) |=> (hw_clear_out == '0))
        else $error("clear pulse too long");

    // a taken high call marks the high level busy
    chk_level_high: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && ack_ok && win_hi_reg) |=> hi_act_reg)
        else $error("high level not marked");

    // a taken low call marks the low level busy
    chk_level_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && ack_ok && !win_hi_reg) |=> lo_act_reg)
        else $error("low level not marked");

    // return from high leaves a preempted low level in place
    chk_level_restore: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_en_in && return_from_irq_op_done_in && !ack_ok && hi_act_reg) |=>
        (!hi_act_reg && lo_act_reg == $past(lo_act_reg)))
        else $error("level not restored on return");

    // enable low freezes request, target and primary enable
    chk_freeze_state: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !clk_en_in |=>
        ($stable(irq_req_out) && $stable(vector_out) && $stable(en0_reg)))
        else $error("state moved while enable low");

    // status outputs trail the level flops by one clock
    chk_status_follow: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        clk_en_in |=>
        (hi_active_out == $past(hi_act_reg) && lo_active_out == $past(lo_act_reg)))
        else $error("level status out of step");
endmodule : two_level_vectored_irq_unit

// ---- irq_unit_pkg.sv ----
// constants, types and register map of the vectored interrupt unit
// assumes an 8-bit register port from the core and same-clock flag sources
package irq_unit_pkg;
    localparam int NUM_SRC  = 19;            // maskable sources
    localparam int IDX_W    = 5;             // source index width
    localparam int GLOBAL_BIT = 7;           // global enable position
    localparam int HWCLR_CNT  = 4;           // sources cleared on vectoring
    localparam int T2_SRC     = 5;           // timer2 source number
    localparam logic [7:0] ADDR_EN0  = 8'hA8; // primary enable
    localparam logic [7:0] ADDR_PRI0 = 8'hB8; // primary priority
    localparam logic [7:0] ADDR_EN1  = 8'hE6; // extended enable 1
    localparam logic [7:0] ADDR_PRI1 = 8'hF6; // extended priority 1
    localparam logic [7:0] ADDR_EN2  = 8'hE7; // extended enable 2
    localparam logic [7:0] ADDR_PRI2 = 8'hF7; // extended priority 2
    localparam logic [7:0] BIT_BASE_MASK = 8'hF8; // byte of a bit address
    localparam logic [7:0] RST_EN    = 8'h00; // enable reset value
    localparam logic [7:0] RST_PRI   = 8'h00; // priority reset value
    localparam logic [7:0] PRI0_FIXED = 8'h80; // priority bit 7 reads one
    localparam logic [7:0] EN2_MASK  = 8'h0F; // implemented extended-2 bits
    localparam logic [15:0] VEC_RESET = 16'h0000; // unmaskable reset entry
    localparam logic [15:0] VEC_BASE  = 16'h0003; // source zero entry
    localparam int DETECT_CYC = 1;           // request detect clocks
    localparam int CALL_CYC   = 5;           // long call clocks
    localparam int RET_CYC    = 5;           // return clocks
    localparam int DIV_CYC    = 8;           // divide clocks
    localparam int MIN_RESP   = DETECT_CYC + 1 + CALL_CYC;                // 7
    localparam int MAX_RESP   = DETECT_CYC + RET_CYC + DIV_CYC + CALL_CYC; // 19

    // byte-wide register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sfr_bus_t;

    // single-bit write from the core
    typedef struct packed {
        logic [7:0] addr;
        logic       val;
        logic       wr;
    } bit_bus_t;
endpackage : irq_unit_pkg

// ---- core_flag_model.sv ----
// core and flag-source model: holds pending flags, takes the long call
// assumes the unit's registered request and one-clock clear pulses
`timescale 1ns/1ps
module core_flag_model
    import irq_unit_pkg::*;
(
    input  wire logic               ref_clk_in,  // system clock
    input  wire logic               rst_in,      // sync reset, high
    input  wire logic               irq_req_in,  // request from the unit
    input  wire logic [NUM_SRC-1:0] hw_clear_in, // clear pulses from the unit
    input  wire logic [NUM_SRC-1:0] set_in,      // source set strobes
    input  wire logic [NUM_SRC-1:0] sw_clr_in,   // software flag clears
    input  wire logic               ack_en_in,   // core may start the call
    output logic      [NUM_SRC-1:0] pend_out,    // pending flags by order
    output logic                    irq_ack_out  // long call begins
);
    // flags set by sources, dropped by software or by the unit's pulse
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pend_out    <= '0;
            irq_ack_out <= 1'b0;
        end else begin
            pend_out    <= (pend_out | set_in) & ~sw_clr_in & ~hw_clear_in;
            // one-cycle call pulse, held off until the bench allows it
            irq_ack_out <= irq_req_in & ack_en_in & ~irq_ack_out;
        end
    end
endmodule : core_flag_model

// ---- tb_top.sv ----
// self-checking bench for the vectored interrupt unit
// assumes the core/flag model beside it and one 100 MHz clock
`timescale 1ns/1ps
module tb_top
    import irq_unit_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, t2h = 1'b0;   // clock, reset, run, t2 high
    logic idone = 1'b0, rdone = 1'b0, ack_en = 1'b0;            // core pulses
    sfr_bus_t           sfr   = '0;                              // byte access
    bit_bus_t           bitb  = '0;                              // bit access
    logic [NUM_SRC-1:0] setm  = '0, swc = '0, pend, hwc;         // flag traffic
    logic [7:0]         rdata;                                   // read data
    logic               req, hi, lo, ack;                        // request status
    logic [15:0]        vec;                                     // call target
    int                 n_errors = 0, cmp_count = 0;             // tallies
    always #5 clk = ~clk;
    two_level_vectored_irq_unit two_level_vectored_irq_unit_inst (.ref_clk_in(clk),
        .rst_in(rst), .clk_en_in(clk_en), .sfr_bus_in(sfr), .bit_bus_in(bitb),
        .pend_in(pend), .t2_high_flag_in(t2h), .instr_done_in(idone), .return_from_irq_op_done_in(rdone),
        .irq_ack_in(ack), .sfr_rdata_out(rdata), .irq_req_out(req), .vector_out(vec),
        .hw_clear_out(hwc), .hi_active_out(hi), .lo_active_out(lo));
    core_flag_model core_flag_model_inst (.ref_clk_in(clk), .rst_in(rst), .irq_req_in(req),
        .hw_clear_in(hwc), .set_in(setm), .sw_clr_in(swc), .ack_en_in(ack_en),
        .pend_out(pend), .irq_ack_out(ack));
    // compare and count
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // byte write, held over one taking edge, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr.addr = a;
        sfr.wdata = d;
        sfr.wr = 1'b1;
        cyc(1);
        sfr.wr = 1'b0;
        cyc(1);
    endtask : wr
    // byte read, data registered on the taking edge, checked at the next falling edge, then idle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr.addr = a;
        sfr.rd = 1'b1;
        cyc(1);
        sfr.rd = 1'b0;
        check(rdata, exp);
        cyc(1);
    endtask : rd
    task automatic wbit(input logic [7:0] a, input logic v);
        bitb.addr = a;
        bitb.val = v;
        bitb.wr = 1'b1;
        cyc(1);
        bitb.wr = 1'b0;
    endtask : wbit
    task automatic set_flags(input logic [NUM_SRC-1:0] m);
        setm = m;
        cyc(1);
        setm = '0;
    endtask : set_flags
    task automatic clr_flags(input logic [NUM_SRC-1:0] m);
        swc = m;
        cyc(1);
        swc = '0;
    endtask : clr_flags
    // bounded wait for the request
    task automatic await_req();
        for (int k = 0; k < 20 && req !== 1'b1; k++) cyc(1);
        check(req, 1'b1);
    endtask : await_req
    // let the model take the call, then look at the clear pulse and flag
    task automatic take(input int i);
        check(vec, VEC_BASE + 16'(8 * i));
        ack_en = 1'b1;
        cyc(1);
        ack_en = 1'b0;
        cyc(1);
        check(hwc, (i < HWCLR_CNT) ? (19'h1 << i) : 19'h0);
        cyc(1);
        check(pend[i], i >= HWCLR_CNT);
        check(req, 1'b0);
    endtask : take
    task automatic ret();
        rdone = 1'b1;
        cyc(1);
        rdone = 1'b0;
        idone = 1'b1;
        cyc(1);
        idone = 1'b0;
    endtask : ret
    // verdict, the only end of the run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    // watchdog far beyond the expected few hundred cycles
    initial begin
        #200000;
        n_errors++;
        close_out();
    end
    // main sequence
    initial begin
        cyc(8);
        rst = 1'b0;
        check(vec, VEC_RESET);
        check({req, hi, lo}, 19'h0);
        rd(ADDR_EN0, RST_EN);
        rd(ADDR_PRI0, PRI0_FIXED);
        wr(ADDR_PRI0, 8'h00);
        rd(ADDR_PRI0, PRI0_FIXED);
        rd(8'h55, 8'h00);
        wbit(8'hAF, 1'b1);
        rd(ADDR_EN0, 8'h80);
        wbit(8'hA8, 1'b1);
        rd(ADDR_EN0, 8'h81);
        // masked by the global bit, then released
        wr(ADDR_EN0, 8'h7F);
        set_flags(19'h1);
        cyc(3);
        check(req, 1'b0);
        wbit(8'hAF, 1'b1);
        await_req();
        take(0);
        ret();
        wr(ADDR_EN1, 8'hFF);
        rd(ADDR_EN1, 8'hFF);
        wr(ADDR_EN2, 8'hFF);
        rd(ADDR_EN2, EN2_MASK);
        rd(ADDR_PRI1, RST_PRI);
        wr(ADDR_PRI2, 8'hFF);
        rd(ADDR_PRI2, EN2_MASK);
        wr(ADDR_PRI2, 8'h00);
        // every source: one detect cycle, vector, clearing
        for (int i = 0; i < NUM_SRC; i++) begin
            set_flags(19'h1 << i);
            check(req, 1'b0);
            cyc(1);
            check(req, 1'b1);
            take(i);
            clr_flags(19'h1 << i);
            ret();
        end
        // higher level first, then fixed order at one level
        wr(ADDR_PRI0, 8'h40);
        wbit(8'hB8, 1'b1);
        rd(ADDR_PRI0, 8'hC1);
        set_flags(19'h44);
        await_req();
        check(vec, 16'h0033);
        wr(ADDR_PRI0, 8'h00);
        cyc(1);
        check(vec, 16'h0013);
        clr_flags(19'h44);
        // low routine preempted by high, high never preempted
        wr(ADDR_PRI0, 8'h0A);
        set_flags(19'h10);
        await_req();
        take(4);
        check(lo, 1'b1);
        set_flags(19'h08);
        await_req();
        take(3);
        check(hi, 1'b1);
        set_flags(19'h02);
        cyc(3);
        check(req, 1'b0);
        clr_flags(19'h02);
        ret();
        check({hi, lo}, 2'b01);
        // flag left set across the return: one instruction, then again
        rdone = 1'b1;
        cyc(1);
        rdone = 1'b0;
        cyc(2);
        check(req, 1'b0);
        idone = 1'b1;
        cyc(1);
        idone = 1'b0;
        check(req, 1'b0);
        cyc(1);
        check(req, 1'b1);
        check(vec, 16'h0023);
        clr_flags(19'h10);
        cyc(1);
        check({req, lo}, 2'b00);
        // clearing the enable stops a pending flag before software clears it
        set_flags(19'h1 << 15);
        await_req();
        check(vec, 16'h007B);
        wr(ADDR_EN2, 8'h00);
        cyc(1);
        check(req, 1'b0);
        clr_flags(19'h1 << 15);
        // timer2 high flag shares the timer2 vector
        t2h = 1'b1;
        await_req();
        check(vec, 16'h002B);
        t2h = 1'b0;
        cyc(2);
        check(req, 1'b0);
        // enable low: no request, writes ignored, then it resumes
        clk_en = 1'b0;
        t2h = 1'b1;
        wr(ADDR_EN0, 8'h00);
        check(req, 1'b0);
        clk_en = 1'b1;
        await_req();
        check(vec, 16'h002B);
        rd(ADDR_EN0, 8'hFF);
        t2h = 1'b0;
        close_out();
    end
endmodule : tb_top
